// file: verilog/udm_pkg.sv
// shared constants, types and the code table of the unit fault diagnostic monitor
package udm_pkg;

  // ==========================================================================
  // types
  typedef logic signed [9:0] udm_temp_t;  // degrees F
  typedef logic signed [7:0] udm_pct_t;   // percent of travel or resistance
  typedef logic [6:0] udm_code_t;         // two-digit diagnostic code

  // ==========================================================================
  // clock and display timing
  localparam int unsigned UDM_CLK_HZ = 25_000_000;
  localparam int unsigned UDM_DISPLAY_HOLD_MS = 1000;
  localparam int unsigned UDM_DISPLAY_HOLD_CYC = UDM_CLK_HZ / 1000 * UDM_DISPLAY_HOLD_MS;
  localparam logic [2:0] UDM_SETTLE_CYC = 3'h4;  // sync pipeline depth plus one

  // ==========================================================================
  // switch input bit positions
  localparam int UDM_SW_LP_LEAD = 0;
  localparam int UDM_SW_LP_LAG = 1;
  localparam int UDM_SW_OIL1 = 2;
  localparam int UDM_SW_OIL2 = 3;
  localparam int UDM_SW_CTL = 4;
  localparam int UDM_SW_BTN = 5;
  localparam int UDM_SW_HDR = 6;
  localparam int UDM_SW_UNL1 = 7;
  localparam int UDM_SW_UNL2 = 8;
  localparam int UDM_SW_RST_EN = 9;
  localparam int UDM_SW_DL_EN = 10;
  localparam int UDM_SW_DL_PRES = 11;
  localparam int UDM_SW_N = 12;

  // ==========================================================================
  // fault record bit positions; bits below UDM_F_N_LATCHED latch until a switch cycle
  localparam int UDM_F_LP_LEAD = 0;
  localparam int UDM_F_LP_LAG = 1;
  localparam int UDM_F_OIL1 = 2;
  localparam int UDM_F_OIL2 = 3;
  localparam int UDM_F_CONFIG = 4;
  localparam int UDM_F_SUP_AIR = 5;
  localparam int UDM_F_RET_AIR = 6;
  localparam int UDM_F_COND1 = 7;
  localparam int UDM_F_COND2 = 8;
  localparam int UDM_F_RST_TEMP = 9;
  localparam int UDM_F_SETPOINT = 10;
  localparam int UDM_F_DAMPER = 11;
  localparam int UDM_F_RST_LIM = 12;
  localparam int UDM_F_DEMAND = 13;
  localparam int UDM_F_MIN_POS = 14;
  localparam int UDM_F_N = 15;
  localparam int UDM_F_N_LATCHED = 5;
  localparam logic [UDM_F_N-1:0] UDM_FAULT_RST = 15'h0000;

  // ==========================================================================
  // limits
  localparam udm_temp_t UDM_THERM_LO_F = udm_temp_t'(-60);
  localparam udm_temp_t UDM_THERM_HI_F = udm_temp_t'(180);
  localparam udm_temp_t UDM_OFFSET_LO_F = udm_temp_t'(40);
  localparam udm_temp_t UDM_OFFSET_HI_F = udm_temp_t'(90);
  localparam udm_temp_t UDM_SP_LO_F = udm_temp_t'(-22);
  localparam udm_temp_t UDM_SP_HI_F = udm_temp_t'(70);
  localparam udm_temp_t UDM_SP_DEFAULT_F = udm_temp_t'(70);
  localparam udm_temp_t UDM_SP_CLAMP_F = udm_temp_t'(45);
  localparam udm_temp_t UDM_SP_RST = udm_temp_t'(70);
  localparam udm_temp_t UDM_RLIM_LO_F = udm_temp_t'(0);
  localparam udm_temp_t UDM_RLIM_HI_F = udm_temp_t'(80);
  localparam udm_pct_t UDM_PCT_MIN = udm_pct_t'(0);
  localparam udm_pct_t UDM_PCT_MAX = udm_pct_t'(100);
  localparam udm_pct_t UDM_DL_LO_PCT = udm_pct_t'(10);
  localparam udm_pct_t UDM_DL_HI_PCT = udm_pct_t'(90);
  localparam udm_pct_t UDM_STUCK_SPAN_PCT = udm_pct_t'(10);
  localparam udm_pct_t UDM_DAMPER_FAIL_PCT = udm_pct_t'(0);

  // ==========================================================================
  // code shown for each fault record bit; unused codes are simply absent
  function automatic udm_code_t udm_code(input logic [3:0] idx);
    case (idx)
      4'h0: udm_code = 7'h3B;  // 59
      4'h1: udm_code = 7'h3C;  // 60
      4'h2: udm_code = 7'h3F;  // 63
      4'h3: udm_code = 7'h40;  // 64
      4'h4: udm_code = 7'h46;  // 70
      4'h5: udm_code = 7'h47;  // 71
      4'h6: udm_code = 7'h48;  // 72
      4'h7: udm_code = 7'h4B;  // 75
      4'h8: udm_code = 7'h4C;  // 76
      4'h9: udm_code = 7'h51;  // 81
      4'hA: udm_code = 7'h52;  // 82
      4'hB: udm_code = 7'h53;  // 83
      4'hC: udm_code = 7'h54;  // 84
      4'hD: udm_code = 7'h55;  // 85
      4'hE: udm_code = 7'h56;  // 86
      default: udm_code = 7'h00;
    endcase
  endfunction : udm_code

endpackage : udm_pkg

// file: verilog/udm_sync_if.sv
// switch bundle between the monitor and its input filter
`timescale 1ns/10ps
interface udm_sync_if #(parameter int N = 12);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface : udm_sync_if

// file: verilog/udm_sync.sv
// three-stage synchroniser with agree filter for the switch pins
`timescale 1ns/10ps
module udm_sync #(parameter int N = 12) (
  input wire logic core_clk,
  input wire logic rst_n,
  udm_sync_if.filt sw
);

  logic [N-1:0] s1_q, s2_q, s3_q, clean_q;

  // ==========================================================================
  // s1 feeds only s2; a bit changes once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= sw.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= (s2_q & s3_q) | (clean_q & (s2_q | s3_q));  // hold while they disagree
    end
  end

  assign sw.clean = clean_q;

endmodule : udm_sync

// file: verilog/udm_monitor.sv
// unit fault diagnostic monitor: fault detection, actions, fault record and code display
`timescale 1ns/10ps
module udm_monitor #(
  parameter int unsigned DISPLAY_HOLD_CYC = udm_pkg::UDM_DISPLAY_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic lp_lead_closed,
  input wire logic lp_lag_closed,
  input wire logic oil1_closed,
  input wire logic oil2_closed,
  input wire logic control_sw_on,
  input wire logic display_button,
  input wire logic header_present,
  input wire logic unloader_sw1_on,
  input wire logic unloader_sw2_on,
  input wire logic reset_enable_sw,
  input wire logic demand_enable_sw,
  input wire logic demand_pot_present,
  input wire udm_pkg::udm_temp_t supply_air_temp,
  input wire udm_pkg::udm_temp_t return_air_temp,
  input wire udm_pkg::udm_temp_t cond1_temp,
  input wire udm_pkg::udm_temp_t cond2_temp,
  input wire logic space_temp_sensor_bad,
  input wire udm_pkg::udm_temp_t reset_offset_knob,
  input wire udm_pkg::udm_temp_t leaving_air_setpoint_knob,
  input wire udm_pkg::udm_pct_t damper_feedback_pot,
  input wire logic damper_stroke_active,
  input wire udm_pkg::udm_temp_t reset_limit_knob,
  input wire udm_pkg::udm_pct_t demand_limit_knob,
  input wire udm_pkg::udm_pct_t min_damper_position_knob,
  output logic unit_run_q,
  output logic circuit1_enable_q,
  output logic circuit2_enable_q,
  output logic alarm_lamp_q,
  output logic reset_allowed_q,
  output logic demand_limit_allowed_q,
  output logic damper_force_closed_q,
  output udm_pkg::udm_pct_t damper_position_q,
  output udm_pkg::udm_temp_t leaving_air_setpoint_q,
  output logic display_valid_q,
  output udm_pkg::udm_code_t display_code_q,
  output logic [udm_pkg::UDM_F_N-1:0] fault_record_q
);

  // ==========================================================================
  // switch filtering
  udm_sync_if #(.N(udm_pkg::UDM_SW_N)) sw_if ();

  assign sw_if.raw = {demand_pot_present, demand_enable_sw, reset_enable_sw, unloader_sw2_on, unloader_sw1_on,
                      header_present, display_button, control_sw_on, oil2_closed, oil1_closed, lp_lag_closed,
                      lp_lead_closed};

  udm_sync #(.N(udm_pkg::UDM_SW_N)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sw(sw_if.filt)
  );

  wire logic [udm_pkg::UDM_SW_N-1:0] sw = sw_if.clean;
  wire logic ctl_on = sw[udm_pkg::UDM_SW_CTL];
  wire logic btn = sw[udm_pkg::UDM_SW_BTN];

  // ==========================================================================
  // state
  logic [2:0] settle_q;
  logic armed_q;
  logic ctl_prev_q;
  logic [udm_pkg::UDM_F_N-1:0] fault_q, fault_d;
  udm_pkg::udm_pct_t tr_min_q, tr_max_q;
  logic stroke_prev_q;
  logic stuck_q;
  logic [3:0] scan_q;
  logic [24:0] hold_q;

  // switch faults wait until the filter has filled, else reset zeros look like open switches
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      settle_q <= 3'h0;
      armed_q <= 1'b0;
      ctl_prev_q <= 1'b0;
    end else begin
      settle_q <= armed_q ? settle_q : settle_q + 3'h1;
      armed_q <= armed_q | (settle_q == udm_pkg::UDM_SETTLE_CYC);
      ctl_prev_q <= ctl_on;
    end
  end

  // ==========================================================================
  // fault conditions
  wire logic ctl_rise = armed_q & ctl_on & ~ctl_prev_q;  // off then on

  function automatic logic therm_bad(input udm_pkg::udm_temp_t t);
    therm_bad = (t < udm_pkg::UDM_THERM_LO_F) || (t > udm_pkg::UDM_THERM_HI_F);
  endfunction : therm_bad

  function automatic logic pct_bad(input udm_pkg::udm_pct_t p);
    pct_bad = (p < udm_pkg::UDM_PCT_MIN) || (p > udm_pkg::UDM_PCT_MAX);
  endfunction : pct_bad

  wire logic config_bad = !sw[udm_pkg::UDM_SW_HDR] || (sw[udm_pkg::UDM_SW_UNL1] && sw[udm_pkg::UDM_SW_UNL2]);
  wire logic offset_bad = (reset_offset_knob < udm_pkg::UDM_OFFSET_LO_F) ||
                          (reset_offset_knob > udm_pkg::UDM_OFFSET_HI_F);
  wire logic sp_bad = (leaving_air_setpoint_knob < udm_pkg::UDM_SP_LO_F) ||
                      (leaving_air_setpoint_knob > udm_pkg::UDM_SP_HI_F);
  wire logic damper_bad = pct_bad(damper_feedback_pot) || stuck_q;
  wire logic rlim_bad = sw[udm_pkg::UDM_SW_RST_EN] && ((reset_limit_knob < udm_pkg::UDM_RLIM_LO_F) ||
                        (reset_limit_knob > udm_pkg::UDM_RLIM_HI_F));
  wire logic dl_bad = sw[udm_pkg::UDM_SW_DL_EN] && (!sw[udm_pkg::UDM_SW_DL_PRES] ||
                      (demand_limit_knob < udm_pkg::UDM_DL_LO_PCT) ||
                      (demand_limit_knob > udm_pkg::UDM_DL_HI_PCT));

  wire logic [udm_pkg::UDM_F_N_LATCHED-1:0] latch_set = {5{armed_q}} & {config_bad,
    !sw[udm_pkg::UDM_SW_OIL2], !sw[udm_pkg::UDM_SW_OIL1],
    !sw[udm_pkg::UDM_SW_LP_LAG], !sw[udm_pkg::UDM_SW_LP_LEAD]};

  // set beats the switch-cycle clear; auto bits simply follow their condition
  always_comb begin
    fault_d[udm_pkg::UDM_F_N_LATCHED-1:0] = latch_set | (fault_q[udm_pkg::UDM_F_N_LATCHED-1:0] & {5{~ctl_rise}});
    fault_d[udm_pkg::UDM_F_SUP_AIR] = therm_bad(supply_air_temp);
    fault_d[udm_pkg::UDM_F_RET_AIR] = therm_bad(return_air_temp);
    fault_d[udm_pkg::UDM_F_COND1] = therm_bad(cond1_temp);
    fault_d[udm_pkg::UDM_F_COND2] = therm_bad(cond2_temp);
    fault_d[udm_pkg::UDM_F_RST_TEMP] = space_temp_sensor_bad || offset_bad;
    fault_d[udm_pkg::UDM_F_SETPOINT] = sp_bad;
    fault_d[udm_pkg::UDM_F_DAMPER] = damper_bad;
    fault_d[udm_pkg::UDM_F_RST_LIM] = rlim_bad;
    fault_d[udm_pkg::UDM_F_DEMAND] = dl_bad;
    fault_d[udm_pkg::UDM_F_MIN_POS] = pct_bad(min_damper_position_knob);
  end

  // fault record holds each active code until its clear condition
  always_ff @(posedge core_clk) begin
    if (!rst_n) fault_q <= udm_pkg::UDM_FAULT_RST;
    else fault_q <= fault_d;
  end

  // ==========================================================================
  // damper travel: span is judged at the end of each commanded full stroke
  wire logic stroke_end = stroke_prev_q & ~damper_stroke_active;
  wire logic stroke_start = ~stroke_prev_q & damper_stroke_active;
  wire udm_pkg::udm_pct_t span = tr_max_q - tr_min_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tr_min_q <= udm_pkg::UDM_PCT_MAX;
      tr_max_q <= udm_pkg::UDM_PCT_MIN;
      stroke_prev_q <= 1'b0;
      stuck_q <= 1'b0;
    end else begin
      stroke_prev_q <= damper_stroke_active;
      tr_min_q <= stroke_start ? damper_feedback_pot :
                  (damper_feedback_pot < tr_min_q ? damper_feedback_pot : tr_min_q);
      tr_max_q <= stroke_start ? damper_feedback_pot :
                  (damper_feedback_pot > tr_max_q ? damper_feedback_pot : tr_max_q);
      stuck_q <= stroke_end ? (span < udm_pkg::UDM_STUCK_SPAN_PCT) : stuck_q;
    end
  end

  // ==========================================================================
  // actions taken from the fault record, the leaving air setpoint from its knob
  wire logic unit_stop = fault_q[udm_pkg::UDM_F_CONFIG] | fault_q[udm_pkg::UDM_F_SUP_AIR] |
                         fault_q[udm_pkg::UDM_F_RET_AIR] | fault_q[udm_pkg::UDM_F_COND1] |
                         fault_q[udm_pkg::UDM_F_COND2];
  wire logic run_d = armed_q & ctl_on & ~unit_stop;
  wire logic c1_d = run_d & ~fault_q[udm_pkg::UDM_F_LP_LEAD] & ~fault_q[udm_pkg::UDM_F_OIL1];
  wire logic c2_d = run_d & ~fault_q[udm_pkg::UDM_F_LP_LAG] & ~fault_q[udm_pkg::UDM_F_OIL2];
  wire logic force_closed_d = fault_q[udm_pkg::UDM_F_DAMPER] | fault_q[udm_pkg::UDM_F_MIN_POS];
  wire udm_pkg::udm_pct_t pos_d = fault_q[udm_pkg::UDM_F_DAMPER] ? udm_pkg::UDM_DAMPER_FAIL_PCT : damper_feedback_pot;
  wire udm_pkg::udm_temp_t sp_d = sp_bad ? udm_pkg::UDM_SP_DEFAULT_F :
    (leaving_air_setpoint_knob < udm_pkg::UDM_SP_CLAMP_F ? udm_pkg::UDM_SP_CLAMP_F : leaving_air_setpoint_knob);
  wire logic rst_ok_d = sw[udm_pkg::UDM_SW_RST_EN] & ~fault_q[udm_pkg::UDM_F_RST_TEMP] &
                        ~fault_q[udm_pkg::UDM_F_RST_LIM];
  wire logic dl_ok_d = sw[udm_pkg::UDM_SW_DL_EN] & ~fault_q[udm_pkg::UDM_F_DEMAND];

  // every output leaves from a flip-flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      unit_run_q <= 1'b0;
      circuit1_enable_q <= 1'b0;
      circuit2_enable_q <= 1'b0;
      alarm_lamp_q <= 1'b0;
      reset_allowed_q <= 1'b0;
      demand_limit_allowed_q <= 1'b0;
      damper_force_closed_q <= 1'b1;
      damper_position_q <= udm_pkg::UDM_DAMPER_FAIL_PCT;
      leaving_air_setpoint_q <= udm_pkg::UDM_SP_RST;
    end else begin
      unit_run_q <= run_d;
      circuit1_enable_q <= c1_d;
      circuit2_enable_q <= c2_d;
      alarm_lamp_q <= |fault_q;
      reset_allowed_q <= rst_ok_d;
      demand_limit_allowed_q <= dl_ok_d;
      damper_force_closed_q <= force_closed_d;
      damper_position_q <= pos_d;
      leaving_air_setpoint_q <= sp_d;
    end
  end

  // ==========================================================================
  // display scan: walks the record while the button is held, each code shown for one hold period
  wire logic cur_active = fault_q[scan_q];
  wire logic hold_done = hold_q == 25'(DISPLAY_HOLD_CYC - 1);
  wire logic advance = btn & (~cur_active | hold_done);
  wire logic [3:0] scan_next = (scan_q == 4'(udm_pkg::UDM_F_N - 1)) ? 4'h0 : scan_q + 4'h1;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scan_q <= 4'h0;
      hold_q <= 25'h0000000;
      display_valid_q <= 1'b0;
      display_code_q <= 7'h00;
      fault_record_q <= udm_pkg::UDM_FAULT_RST;
    end else begin
      scan_q <= !btn ? 4'h0 : (advance ? scan_next : scan_q);
      hold_q <= (!btn || advance) ? 25'h0000000 : hold_q + 25'h0000001;
      display_valid_q <= btn & cur_active;
      display_code_q <= (btn & cur_active) ? udm_pkg::udm_code(scan_q) : 7'h00;
      fault_record_q <= fault_q;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence lp_lead_latched;
    fault_q[udm_pkg::UDM_F_LP_LEAD] ##1 !circuit1_enable_q;
  endsequence

  config_stops_unit_a: assert property (armed_q && config_bad |=> fault_q[udm_pkg::UDM_F_CONFIG] ##1 !unit_run_q)
    else $error("illegal configuration did not stop the unit");
  auto_restart_a: assert property (armed_q && ctl_on && !unit_stop |=> unit_run_q)
    else $error("unit did not restart after faults cleared");
  latch_hold_a: assert property (fault_q[udm_pkg::UDM_F_OIL1] && !ctl_rise |=> fault_q[udm_pkg::UDM_F_OIL1])
    else $error("latched fault cleared without a switch cycle");
  code_legal_a: assert property (display_valid_q |-> display_code_q inside {7'h3B, 7'h3C, 7'h3F, 7'h40,
    [7'h46:7'h48], 7'h4B, 7'h4C, [7'h51:7'h56]})
    else $error("unused diagnostic code shown");
  lp_lockout_a: assert property (armed_q && !sw[udm_pkg::UDM_SW_LP_LEAD] |=> lp_lead_latched)
    else $error("open low-pressure switch did not lock circuit one");
  display_blank_a: assert property (!btn |=> !display_valid_q && display_code_q == 7'h00)
    else $error("code shown without the button");
  oil_open_a: assert property (armed_q && !sw[udm_pkg::UDM_SW_OIL2] |=>
    fault_q[udm_pkg::UDM_F_OIL2] ##1 !circuit2_enable_q)
    else $error("open oil input did not stop circuit two");
  therm_stop_a: assert property (therm_bad(cond2_temp) |=> fault_q[udm_pkg::UDM_F_COND2] ##1 !unit_run_q)
    else $error("thermistor fault did not stop the unit");
  therm_clear_a: assert property (!therm_bad(supply_air_temp) |=> !fault_q[udm_pkg::UDM_F_SUP_AIR])
    else $error("thermistor fault did not clear itself");
  sp_default_a: assert property (sp_bad |=> leaving_air_setpoint_q == udm_pkg::UDM_SP_DEFAULT_F &&
    fault_q[udm_pkg::UDM_F_SETPOINT] ##1 alarm_lamp_q)
    else $error("bad setpoint not replaced by default");
  sp_clamp_a: assert property (!sp_bad && leaving_air_setpoint_knob < udm_pkg::UDM_SP_CLAMP_F |=>
    leaving_air_setpoint_q == udm_pkg::UDM_SP_CLAMP_F && !fault_q[udm_pkg::UDM_F_SETPOINT])
    else $error("low setpoint not clamped");
  damper_close_a: assert property (fault_q[udm_pkg::UDM_F_DAMPER] |=> damper_force_closed_q &&
    damper_position_q == udm_pkg::UDM_DAMPER_FAIL_PCT)
    else $error("damper fault did not close dampers");
  reset_stop_a: assert property (rlim_bad || offset_bad |=> ##1 !reset_allowed_q)
    else $error("reset not stopped on fault");
  demand_stop_a: assert property (dl_bad |=> fault_q[udm_pkg::UDM_F_DEMAND] ##1 !demand_limit_allowed_q)
    else $error("demand limit not stopped on fault");

  // stuck dampers are judged when a stroke ends, then carried into the record
  sequence damper_stuck_seen;
    stuck_q ##1 fault_q[udm_pkg::UDM_F_DAMPER];
  endsequence
  stuck_damper_a: assert property (stroke_end && span < udm_pkg::UDM_STUCK_SPAN_PCT |=> damper_stuck_seen)
    else $error("stuck damper travel not reported");
  dl_missing_a: assert property (sw[udm_pkg::UDM_SW_DL_EN] && !sw[udm_pkg::UDM_SW_DL_PRES] |=>
    fault_q[udm_pkg::UDM_F_DEMAND])
    else $error("missing demand knob not reported");
  // record first, then the dampers and the lamp follow one edge later
  sequence min_pos_closed;
    fault_q[udm_pkg::UDM_F_MIN_POS] ##1 damper_force_closed_q && alarm_lamp_q;
  endsequence
  min_pos_close_a: assert property (pct_bad(min_damper_position_knob) |=> min_pos_closed)
    else $error("bad minimum position did not close dampers");
  supply_code_a: assert property (therm_bad(supply_air_temp) |=> fault_q[udm_pkg::UDM_F_SUP_AIR])
    else $error("supply air fault not recorded");
  lp_clear_a: assert property (ctl_rise && sw[udm_pkg::UDM_SW_LP_LEAD] |=> !fault_q[udm_pkg::UDM_F_LP_LEAD])
    else $error("switch cycle did not clear the low-pressure fault");
  display_show_a: assert property (btn && cur_active |=> display_valid_q && display_code_q != 7'h00)
    else $error("active code not shown while the button is held");

endmodule : udm_monitor

// file: bench/udm_plant_model.sv
// model of the switches, sensors, knobs and display button around the monitor
`timescale 1ns/10ps
module udm_plant_model (
  input wire logic [3:0] fault_sel,
  input wire logic fault_on,
  input wire logic sp_low,
  input wire logic [4:0] bump,
  input wire logic ctl_on,
  input wire logic button,
  output logic [udm_pkg::UDM_SW_N-1:0] sw,
  output udm_pkg::udm_temp_t tmp [0:6],
  output udm_pkg::udm_pct_t pct [0:2],
  output logic space_bad
);
  // ==========================================================================
  // healthy plant, then one injected fault chosen by fault_sel; bump varies how far out it reads
  always_comb begin
    sw = 12'hE4F;
    sw[udm_pkg::UDM_SW_CTL] = ctl_on;
    sw[udm_pkg::UDM_SW_BTN] = button;
    tmp = '{10'h046, 10'h046, 10'h064, 10'h064, 10'h03C, 10'h037, 10'h028};
    pct = '{8'h32, 8'h32, 8'h14};
    space_bad = fault_on && fault_sel == 4'h9 && bump[0];
    if (sp_low) begin
      tmp[5] = udm_pkg::UDM_SP_LO_F + 10'(bump);
    end
    if (fault_on) begin
      case (fault_sel)
        4'h0, 4'h1, 4'h2, 4'h3: sw[fault_sel] = 1'b0;
        4'h4: sw[udm_pkg::UDM_SW_HDR] = bump[0] ? 1'b0 : 1'b1;
        4'h5, 4'h6, 4'h7, 4'h8: tmp[fault_sel - 4'h5] = udm_pkg::UDM_THERM_HI_F + 10'h001 + 10'(bump);
        4'h9: tmp[4] = bump[0] ? tmp[4] : udm_pkg::UDM_OFFSET_HI_F + 10'h001 + 10'(bump);
        4'hA: tmp[5] = udm_pkg::UDM_SP_HI_F + 10'h001 + 10'(bump);
        4'hB: pct[0] = 8'hFF - 8'(bump);
        4'hC: tmp[6] = udm_pkg::UDM_RLIM_HI_F + 10'h001 + 10'(bump);
        4'hD: pct[1] = bump[0] ? pct[1] : udm_pkg::UDM_DL_HI_PCT + 8'h01 + 8'(bump);
        4'hE: pct[2] = 8'hFF - 8'(bump);
        default: ;
      endcase
      // header pulled, or else both unloaders on; knob missing, or else out of range
      if (fault_sel == 4'h4 && !bump[0]) begin
        sw[8:7] = 2'h3;
      end
      if (fault_sel == 4'hD && bump[0]) begin
        sw[udm_pkg::UDM_SW_DL_PRES] = 1'b0;
      end
    end
  end
endmodule : udm_plant_model

// file: bench/udm_monitor_test.sv
// self-checking bench: fault injection, latch and clear, display scan, setpoint clamp
`timescale 1ns/10ps
module udm_monitor_test;
  logic core_clk = 1'b0, rst_n = 1'b0, fault_on = 1'b0, sp_low = 1'b0, ctl_on = 1'b1, button = 1'b0;
  logic [3:0] fault_sel = 4'h0;
  logic stroke = 1'b0;
  logic [4:0] bump = 5'h00;
  logic [11:0] sw;
  udm_pkg::udm_temp_t tmp [0:6];
  udm_pkg::udm_pct_t pct [0:2];
  logic space_bad, unit_run_q, circuit1_enable_q, circuit2_enable_q, alarm_lamp_q, reset_allowed_q;
  logic demand_limit_allowed_q, damper_force_closed_q, display_valid_q;
  udm_pkg::udm_pct_t damper_position_q;
  udm_pkg::udm_temp_t leaving_air_setpoint_q, exp_sp;
  udm_pkg::udm_code_t display_code_q;
  logic [14:0] fault_record_q;
  logic [14:0] exp_q [$];
  event chk_ev;
  int err_count = 0, checks_done = 0;
  logic [6:0] code_tab [0:14] = '{7'h3B, 7'h3C, 7'h3F, 7'h40, 7'h46, 7'h47, 7'h48, 7'h4B, 7'h4C, 7'h51, 7'h52,
    7'h53, 7'h54, 7'h55, 7'h56};

  // ==========================================================================
  // plant and monitor; the bench commands the damper strokes itself
  udm_plant_model plant (.fault_sel(fault_sel), .fault_on(fault_on), .sp_low(sp_low), .bump(bump),
    .ctl_on(ctl_on), .button(button), .sw(sw), .tmp(tmp), .pct(pct), .space_bad(space_bad));
  udm_monitor #(.DISPLAY_HOLD_CYC(8)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .lp_lead_closed(sw[udm_pkg::UDM_SW_LP_LEAD]), .lp_lag_closed(sw[udm_pkg::UDM_SW_LP_LAG]),
    .oil1_closed(sw[udm_pkg::UDM_SW_OIL1]), .oil2_closed(sw[udm_pkg::UDM_SW_OIL2]),
    .control_sw_on(sw[udm_pkg::UDM_SW_CTL]), .display_button(sw[udm_pkg::UDM_SW_BTN]),
    .header_present(sw[udm_pkg::UDM_SW_HDR]), .unloader_sw1_on(sw[udm_pkg::UDM_SW_UNL1]),
    .unloader_sw2_on(sw[udm_pkg::UDM_SW_UNL2]), .reset_enable_sw(sw[udm_pkg::UDM_SW_RST_EN]),
    .demand_enable_sw(sw[udm_pkg::UDM_SW_DL_EN]), .demand_pot_present(sw[udm_pkg::UDM_SW_DL_PRES]),
    .supply_air_temp(tmp[0]), .return_air_temp(tmp[1]), .cond1_temp(tmp[2]), .cond2_temp(tmp[3]),
    .space_temp_sensor_bad(space_bad), .reset_offset_knob(tmp[4]), .leaving_air_setpoint_knob(tmp[5]),
    .damper_feedback_pot(pct[0]), .damper_stroke_active(stroke), .reset_limit_knob(tmp[6]),
    .demand_limit_knob(pct[1]), .min_damper_position_knob(pct[2]), .unit_run_q(unit_run_q),
    .circuit1_enable_q(circuit1_enable_q), .circuit2_enable_q(circuit2_enable_q), .alarm_lamp_q(alarm_lamp_q),
    .reset_allowed_q(reset_allowed_q), .demand_limit_allowed_q(demand_limit_allowed_q),
    .damper_force_closed_q(damper_force_closed_q), .damper_position_q(damper_position_q),
    .leaving_air_setpoint_q(leaving_air_setpoint_q), .display_valid_q(display_valid_q),
    .display_code_q(display_code_q), .fault_record_q(fault_record_q));

  // ==========================================================================
  // clock, comparison and closing tasks
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  // settle long enough for the switch filter, then leave a note for the watcher
  task automatic settle_check(input logic [14:0] e);
    repeat (10) @(negedge core_clk);
    exp_q.push_back(e);
    ->chk_ev;
    #1;  // the watcher reads the plant before the next stimulus moves it
  endtask : settle_check
  // hold the button until the one active code comes round, then release
  task automatic show(input int s);
    int n;
    n = 0;
    check(16'(display_valid_q), 16'h0000);
    button = 1'b1;
    while (display_valid_q !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    check(16'(display_code_q), 16'(code_tab[s]));
    button = 1'b0;
    repeat (8) @(negedge core_clk);
    check(16'(display_valid_q), 16'h0000);
  endtask : show

  // ==========================================================================
  // watcher: every note is compared against the settled outputs
  always @(chk_ev) begin : watch
    logic [14:0] e;
    e = exp_q.pop_front();
    exp_sp = e[10] ? udm_pkg::UDM_SP_DEFAULT_F : (tmp[5] < udm_pkg::UDM_SP_CLAMP_F ? udm_pkg::UDM_SP_CLAMP_F : tmp[5]);
    check(16'(fault_record_q), 16'(e));
    check(16'(alarm_lamp_q), 16'(|e));
    check(16'(unit_run_q), 16'(~|e[8:4]));
    check(16'(leaving_air_setpoint_q), 16'(exp_sp));
    check(16'(circuit1_enable_q), 16'(~|e[8:4] & !(e[0] | e[2])));
    check(16'(circuit2_enable_q), 16'(~|e[8:4] & !(e[1] | e[3])));
    check(16'(reset_allowed_q), 16'(!(e[9] | e[12])));
    check(16'(demand_limit_allowed_q), 16'(!e[13]));
    check(16'(damper_force_closed_q), 16'(e[11] | e[14]));
    check(16'(damper_position_q), 16'(e[11] ? udm_pkg::UDM_DAMPER_FAIL_PCT : pct[0]));
  end

  // ==========================================================================
  // main sequence: each fault raised, shown, removed, and cleared the way its kind clears
  initial begin
    void'($urandom(96719));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    settle_check(15'h0000);
    for (int s = 0; s < 15; s++) begin
      fault_sel = 4'(s);
      bump = 5'($urandom);
      fault_on = 1'b1;
      settle_check(15'h0001 << s);
      show(s);
      fault_on = 1'b0;
      if (s < udm_pkg::UDM_F_N_LATCHED) begin
        settle_check(15'h0001 << s);
        ctl_on = 1'b0;
        repeat (10) @(negedge core_clk);
        ctl_on = 1'b1;
      end
      settle_check(15'h0000);
      $display("fault test %0d done", s);
    end
    sp_low = 1'b1;
    settle_check(15'h0000);
    $display("setpoint clamp test done");
    // a stroke with no feedback travel reads as stuck dampers; a wide swing clears it
    stroke = 1'b1;
    repeat (6) @(negedge core_clk);
    stroke = 1'b0;
    settle_check(15'h0800);
    stroke = 1'b1;
    fault_sel = 4'hB;
    fault_on = 1'b1;
    repeat (3) @(negedge core_clk);
    fault_on = 1'b0;
    repeat (3) @(negedge core_clk);
    stroke = 1'b0;
    settle_check(15'h0000);
    $display("damper stroke test done");
    finish_test();
  end
  // watchdog well beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    finish_test();
  end
endmodule : udm_monitor_test
